/* core/aps_bank.sv */
// Auto-power-down source selection bank with Avalon-MM slave.
// Assumes alarms are synchronous levels; one answer cycle per access.
//
// How it works
// - Index 0x47 bit 13: external alarm trips group A pins; resets 0.
// - Index 0x47 bit 12: reference alarm trips group A pins; resets 1.
// - Index 0x47 bit 11: thermal error trips group A pins; resets 1.
// - Index 0x47 bits 5,4: negative rails B,A trip group A pins; reset 1.
// - Index 0x47 bits 1,0: positive rails B,A trip group A pins; reset 1.
// - Index 0x48 bit 8: temperature trips group B converters; resets 0.
// - Index 0x48 bits 5,4: converter inputs 1,0 trip B converters; reset 0.
// - Index 0x48 bits 1,0: current senses 1,0 trip B converters; reset 0.
// - Index 0x49 bit 13: external alarm trips group B converters; resets 0.
// - Index 0x49 bits 12,11: reference, thermal trip B converters; reset 1.
// - Index 0x49 bits 5,4,1,0: supply rails trip B converters; reset 1.
// - Index 0x4a bit 8: temperature trips group B pins; resets 0.
// - Index 0x4a bits 5,4: converter inputs 1,0 trip group B pins.
// - Index 0x4a bits 1,0: current senses 1,0 trip group B pins.
// - An event acts only on channels or pins armed in the arm register.
// - Second source registers reset to 0x1833, first ones to 0x0000.
// - Reserved bits are read-only and read as zero.
// - Index 0x4b holds group B pin selections in the same layout.
// - Pin arm code 00 ignores, 10 ties negative, 11 follows clamp.
// - Converter arm bit 0 ignores events, 1 allows power-down.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module aps_bank (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [aps_pkg::BUS_AW-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic [1:0] o_response,
	input wire aps_pkg::aps_alarm_s i_alarm,
	output logic o_event_a_pin,
	output logic o_event_b_dac,
	output logic o_event_b_pin,
	output logic [3:0] o_b_dac_pd,
	output aps_pkg::aps_pin_s o_a_pin,
	output aps_pkg::aps_pin_s o_b_pin
);

	typedef struct packed {
		aps_pkg::aps_bus_e bus;
		logic [15:0] a_pin_hi;
		logic [15:0] b_dac_lo;
		logic [15:0] b_dac_hi;
		logic [15:0] b_pin_lo;
		logic [15:0] b_pin_hi;
		logic [15:0] arm;
		logic [31:0] rdata;
		logic [1:0] resp;
		logic ev_a_pin;
		logic ev_b_dac;
		logic ev_b_pin;
		logic [3:0] b_dac_pd;
		aps_pkg::aps_pin_s a_pin;
		aps_pkg::aps_pin_s b_pin;
	} aps_state_s;

	aps_state_s st;
	aps_state_s next_st;

	logic ev_a_pin;
	logic ev_b_dac;
	logic ev_b_pin;
	logic [7:0] idx;
	logic [15:0] wdata;
	logic [15:0] rd_word;
	logic hit;

	// Merge write data into a register under a writable mask
	function automatic logic [15:0] aps_merge(input logic [15:0] cur,
		input logic [15:0] wd, input logic [1:0] be,
		input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
		return (cur & ~lanes) | (wd & lanes);
	endfunction

	// Power-down action for one switched pin from its arm code
	function automatic logic [2:0] aps_pin_act(input logic ev,
		input logic [1:0] code);
		logic [2:0] act;
		act = 3'b000;
		if (ev) begin
			case (code)
				aps_pkg::PIN_TIE_NEG: act = 3'b110;
				aps_pkg::PIN_TIE_CLAMP: act = 3'b101;
				default: act = 3'b000;
			endcase
		end
		return act;
	endfunction

	aps_event u_ev_a_pin (
		.i_alarm(i_alarm),
		.i_src_lo(16'h0000),
		.i_src_hi(st.a_pin_hi),
		.i_has_lo(1'b0),
		.o_event(ev_a_pin)
	);

	aps_event u_ev_b_dac (
		.i_alarm(i_alarm),
		.i_src_lo(st.b_dac_lo),
		.i_src_hi(st.b_dac_hi),
		.i_has_lo(1'b1),
		.o_event(ev_b_dac)
	);

	aps_event u_ev_b_pin (
		.i_alarm(i_alarm),
		.i_src_lo(st.b_pin_lo),
		.i_src_hi(st.b_pin_hi),
		.i_has_lo(1'b1),
		.o_event(ev_b_pin)
	);

	assign idx = i_address[aps_pkg::BUS_AW-1:2];
	assign wdata = i_writedata[15:0];

	always_comb begin
		hit = 1'b1;
		case (idx)
			aps_pkg::IDX_A_PIN_HI: rd_word = st.a_pin_hi;
			aps_pkg::IDX_B_DAC_LO: rd_word = st.b_dac_lo;
			aps_pkg::IDX_B_DAC_HI: rd_word = st.b_dac_hi;
			aps_pkg::IDX_B_PIN_LO: rd_word = st.b_pin_lo;
			aps_pkg::IDX_B_PIN_HI: rd_word = st.b_pin_hi;
			aps_pkg::IDX_ARM: rd_word = st.arm;
			default: begin
				rd_word = 16'h0000;
				hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		logic [2:0] act;
		logic [1:0] ca;
		logic [1:0] cb;
		act = 3'b000;
		ca = 2'b00;
		cb = 2'b00;
		next_st = st;
		next_st.ev_a_pin = ev_a_pin;
		next_st.ev_b_dac = ev_b_dac;
		next_st.ev_b_pin = ev_b_pin;
		// Converter outputs act only where their arm bit is set
		next_st.b_dac_pd = st.arm[7:4] & {4{ev_b_dac}};
		for (int i = 0; i < 2; i++) begin
			ca = st.arm[8 + 2 * i +: 2];
			cb = st.arm[12 + 2 * i +: 2];
			act = aps_pin_act(ev_a_pin, ca);
			next_st.a_pin.pd[i] = act[2];
			next_st.a_pin.tie_neg[i] = act[1];
			next_st.a_pin.tie_clamp[i] = act[0];
			act = aps_pin_act(ev_b_pin, cb);
			next_st.b_pin.pd[i] = act[2];
			next_st.b_pin.tie_neg[i] = act[1];
			next_st.b_pin.tie_clamp[i] = act[0];
		end
		case (st.bus)
			aps_pkg::BUS_IDLE: begin
				if (i_read || i_write) begin
					next_st.bus = aps_pkg::BUS_DONE;
					next_st.rdata = {16'h0000, rd_word};
					next_st.resp = hit ? 2'b00 : 2'b11;
				end
			end
			aps_pkg::BUS_DONE: begin
				next_st.bus = aps_pkg::BUS_IDLE;
			end
			default: next_st.bus = aps_pkg::BUS_IDLE;
		endcase
		if (st.bus == aps_pkg::BUS_IDLE && i_write) begin
			case (idx)
				aps_pkg::IDX_A_PIN_HI: next_st.a_pin_hi = aps_merge(
					st.a_pin_hi, wdata, i_byteenable[1:0],
					aps_pkg::MASK_HI);
				aps_pkg::IDX_B_DAC_LO: next_st.b_dac_lo = aps_merge(
					st.b_dac_lo, wdata, i_byteenable[1:0],
					aps_pkg::MASK_LO);
				aps_pkg::IDX_B_DAC_HI: next_st.b_dac_hi = aps_merge(
					st.b_dac_hi, wdata, i_byteenable[1:0],
					aps_pkg::MASK_HI);
				aps_pkg::IDX_B_PIN_LO: next_st.b_pin_lo = aps_merge(
					st.b_pin_lo, wdata, i_byteenable[1:0],
					aps_pkg::MASK_LO);
				aps_pkg::IDX_B_PIN_HI: next_st.b_pin_hi = aps_merge(
					st.b_pin_hi, wdata, i_byteenable[1:0],
					aps_pkg::MASK_HI);
				aps_pkg::IDX_ARM: next_st.arm = aps_merge(
					st.arm, wdata, i_byteenable[1:0],
					aps_pkg::MASK_ARM);
				default: next_st.arm = st.arm;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st <= '0;
			st.bus <= aps_pkg::BUS_IDLE;
			st.a_pin_hi <= aps_pkg::RST_HI;
			st.b_dac_lo <= aps_pkg::RST_LO;
			st.b_dac_hi <= aps_pkg::RST_HI;
			st.b_pin_lo <= aps_pkg::RST_LO;
			st.b_pin_hi <= aps_pkg::RST_HI;
			st.arm <= aps_pkg::RST_ARM;
		end else begin
			st <= next_st;
		end
	end

	// Request held until this goes low in the answer cycle
	assign o_waitrequest = (i_read || i_write) && st.bus != aps_pkg::BUS_DONE;
	assign o_readdata = st.rdata;
	assign o_response = st.resp;
	assign o_event_a_pin = st.ev_a_pin;
	assign o_event_b_dac = st.ev_b_dac;
	assign o_event_b_pin = st.ev_b_pin;
	assign o_b_dac_pd = st.b_dac_pd;
	assign o_a_pin = st.a_pin;
	assign o_b_pin = st.b_pin;

endmodule // aps_bank

/* core/aps_event.sv */
// Event combiner for one target group: OR of selected alarms.
// Assumes alarm levels synchronous to the clock.
`timescale 1ns/1ps
module aps_event (
	input wire aps_pkg::aps_alarm_s i_alarm,
	input wire logic [15:0] i_src_lo,
	input wire logic [15:0] i_src_hi,
	input wire logic i_has_lo,
	output logic o_event
);
	logic hi_hit;
	logic lo_hit;

	always_comb begin
		hi_hit = (i_alarm.ext_alarm & i_src_hi[aps_pkg::BIT_EXT_ALARM])
			| (i_alarm.reference & i_src_hi[aps_pkg::BIT_REFERENCE])
			| (i_alarm.thermal & i_src_hi[aps_pkg::BIT_THERMAL])
			| (i_alarm.neg_supply_b & i_src_hi[aps_pkg::BIT_NEG_B])
			| (i_alarm.neg_supply_a & i_src_hi[aps_pkg::BIT_NEG_A])
			| (i_alarm.pos_supply_b & i_src_hi[aps_pkg::BIT_POS_B])
			| (i_alarm.pos_supply_a & i_src_hi[aps_pkg::BIT_POS_A]);
		lo_hit = (i_alarm.temperature & i_src_lo[aps_pkg::BIT_TEMPERATURE])
			| (i_alarm.conv_input1 & i_src_lo[aps_pkg::BIT_CONV1])
			| (i_alarm.conv_input0 & i_src_lo[aps_pkg::BIT_CONV0])
			| (i_alarm.current_sense1 & i_src_lo[aps_pkg::BIT_SENSE1])
			| (i_alarm.current_sense0 & i_src_lo[aps_pkg::BIT_SENSE0]);
		o_event = hi_hit | (i_has_lo & lo_hit);
	end

endmodule // aps_event

/* inc/aps_pkg.sv */
// Package for the auto-power-down source selection register bank.
// Assumes one clock domain and a 32-bit byte-addressed register bus.
package aps_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_A_PIN_HI = 8'h47;
	localparam logic [7:0] IDX_B_DAC_LO = 8'h48;
	localparam logic [7:0] IDX_B_DAC_HI = 8'h49;
	localparam logic [7:0] IDX_B_PIN_LO = 8'h4a;
	localparam logic [7:0] IDX_B_PIN_HI = 8'h4b;
	localparam logic [7:0] IDX_ARM = 8'h60;

	localparam int BUS_AW = 10;

	// Field positions
	localparam int BIT_EXT_ALARM = 13;
	localparam int BIT_REFERENCE = 12;
	localparam int BIT_THERMAL = 11;
	localparam int BIT_TEMPERATURE = 8;
	localparam int BIT_NEG_B = 5;
	localparam int BIT_NEG_A = 4;
	localparam int BIT_POS_B = 1;
	localparam int BIT_POS_A = 0;
	localparam int BIT_CONV1 = 5;
	localparam int BIT_CONV0 = 4;
	localparam int BIT_SENSE1 = 1;
	localparam int BIT_SENSE0 = 0;

	// Writable masks and reset values
	localparam logic [15:0] MASK_HI = 16'h3833;
	localparam logic [15:0] MASK_LO = 16'h0133;
	localparam logic [15:0] RST_HI = 16'h1833;
	localparam logic [15:0] RST_LO = 16'h0000;
	localparam logic [15:0] RST_ARM = 16'haaff;
	localparam logic [15:0] MASK_ARM = 16'hffff;

	// Pin arm codes
	localparam logic [1:0] PIN_IGNORE = 2'b00;
	localparam logic [1:0] PIN_TIE_NEG = 2'b10;
	localparam logic [1:0] PIN_TIE_CLAMP = 2'b11;

	// Alarm inputs, one bit per monitored source
	typedef struct packed {
		logic ext_alarm;
		logic reference;
		logic thermal;
		logic temperature;
		logic conv_input1;
		logic conv_input0;
		logic current_sense1;
		logic current_sense0;
		logic neg_supply_b;
		logic neg_supply_a;
		logic pos_supply_b;
		logic pos_supply_a;
	} aps_alarm_s;

	// Per-pin power-down action
	typedef struct packed {
		logic [1:0] pd;
		logic [1:0] tie_neg;
		logic [1:0] tie_clamp;
	} aps_pin_s;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_DONE = 2'b01
	} aps_bus_e;

endpackage

/* verif/aps_bank_chk.sv */
// Checker for the auto-power-down source bank, on its top ports only.
// Assumes one clock domain and one wait cycle per bus access.
`timescale 1ns/1ps
module aps_chk (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [aps_pkg::BUS_AW-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	input wire logic [1:0] o_response,
	input wire aps_pkg::aps_alarm_s i_alarm,
	input wire logic o_event_a_pin,
	input wire logic o_event_b_dac,
	input wire logic o_event_b_pin,
	input wire logic [3:0] o_b_dac_pd,
	input wire aps_pkg::aps_pin_s o_a_pin,
	input wire aps_pkg::aps_pin_s o_b_pin
);
	logic [7:0] idx;
	logic ans;
	assign idx = i_address[9:2];
	assign ans = i_read && !o_waitrequest;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence taken_s;
		(i_read || i_write) && o_waitrequest;
	endsequence
	sequence answer_s;
		!o_waitrequest;
	endsequence
	one_wait_a: assert property (taken_s |=> answer_s)
		else $error("access not answered after one wait cycle");
	hi_reserved_a: assert property (ans && idx inside {8'h47, 8'h49, 8'h4b}
		|-> (o_readdata[15:0] & ~aps_pkg::MASK_HI) == 16'h0000)
		else $error("reserved bit set in a second source register");
	lo_reserved_a: assert property (ans && idx inside {8'h48, 8'h4a}
		|-> (o_readdata[15:0] & ~aps_pkg::MASK_LO) == 16'h0000)
		else $error("reserved bit set in a first source register");
	upper_zero_a: assert property (ans |-> o_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	unmapped_a: assert property (ans && !(idx inside {[8'h47:8'h4b], 8'h60})
		|-> o_response == 2'b11 && o_readdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	quiet_a: assert property (i_alarm == '0
		|=> !(o_event_a_pin || o_event_b_dac || o_event_b_pin))
		else $error("event without any alarm");
	dac_cause_a: assert property (o_b_dac_pd != 4'h0 |-> o_event_b_dac)
		else $error("converter down without event");
	bpin_cause_a: assert property (o_b_pin.pd != 2'b00 |-> o_event_b_pin)
		else $error("group B pin down without event");
	apin_cause_a: assert property (o_a_pin.pd != 2'b00 |-> o_event_a_pin)
		else $error("group A pin down without event");
endmodule // aps_chk
bind aps_bank aps_chk aps_chk_inst (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(i_address),
	.i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest), .o_response(o_response),
	.i_alarm(i_alarm), .o_event_a_pin(o_event_a_pin),
	.o_event_b_dac(o_event_b_dac), .o_event_b_pin(o_event_b_pin),
	.o_b_dac_pd(o_b_dac_pd), .o_a_pin(o_a_pin), .o_b_pin(o_b_pin)
);

/* verif/aps_bank_tb.sv */
// Self-checking bench for the auto-power-down source bank.
// Assumes the bank answers each Avalon access after one wait cycle.
`timescale 1ns/1ps
module aps_bank_tb;
	localparam logic [7:0] IX [6] = '{aps_pkg::IDX_A_PIN_HI,
		aps_pkg::IDX_B_DAC_LO, aps_pkg::IDX_B_DAC_HI, aps_pkg::IDX_B_PIN_LO,
		aps_pkg::IDX_B_PIN_HI, aps_pkg::IDX_ARM};
	localparam logic [15:0] RV [6] = '{aps_pkg::RST_HI, aps_pkg::RST_LO,
		aps_pkg::RST_HI, aps_pkg::RST_LO, aps_pkg::RST_HI, aps_pkg::RST_ARM};
	localparam logic [15:0] MK [6] = '{aps_pkg::MASK_HI, aps_pkg::MASK_LO,
		aps_pkg::MASK_HI, aps_pkg::MASK_LO, aps_pkg::MASK_HI, aps_pkg::MASK_ARM};
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [9:0] i_address = '0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = '0;
	logic [3:0] i_byteenable = 4'h3;
	aps_pkg::aps_alarm_s i_alarm = '0;
	logic [31:0] o_readdata, rd;
	logic o_waitrequest, o_event_a_pin, o_event_b_dac, o_event_b_pin;
	logic [1:0] o_response, resp;
	logic [3:0] o_b_dac_pd;
	aps_pkg::aps_pin_s o_a_pin, o_b_pin;
	int n_mismatch = 0;
	int n_tests = 0;
	always #4 i_clk = ~i_clk;
	aps_bank aps_bank_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.o_response(o_response), .i_alarm(i_alarm),
		.o_event_a_pin(o_event_a_pin), .o_event_b_dac(o_event_b_dac),
		.o_event_b_pin(o_event_b_pin), .o_b_dac_pd(o_b_dac_pd),
		.o_a_pin(o_a_pin), .o_b_pin(o_b_pin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [7:0] ix,
		input logic [15:0] wd);
		int n;
		i_address <= {ix, 2'b00};
		i_read <= !wr;
		i_write <= wr;
		i_writedata <= {16'h0000, wd};
		// Mid-cycle value equals what the next rising edge samples
		for (n = 0; n < 20; n++) begin
			@(negedge i_clk);
			if (o_waitrequest === 1'b0)
				break;
		end
		rd = o_readdata;
		resp = o_response;
		@(posedge i_clk);
		i_read <= 1'b0;
		i_write <= 1'b0;
		@(posedge i_clk);
	endtask
	// Outputs settle one cycle after the alarm change
	task automatic ev(input logic [11:0] a, input logic [18:0] exp);
		i_alarm <= a;
		repeat (2) @(posedge i_clk);
		check({13'h0000, o_event_a_pin, o_event_b_dac, o_event_b_pin,
			o_b_dac_pd, o_a_pin, o_b_pin}, {13'h0000, exp});
	endtask
	task automatic give_verdict;
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			acc(1'b0, IX[k], 16'h0000);
			check(rd, {16'h0000, RV[k]});
		end
		for (int k = 0; k < 6; k++) begin
			acc(1'b1, IX[k], 16'hffff);
			acc(1'b0, IX[k], 16'h0000);
			check(rd, {16'h0000, MK[k]});
			acc(1'b1, IX[k], 16'h0000);
		end
		acc(1'b1, 8'h50, 16'hffff);
		acc(1'b0, 8'h50, 16'h0000);
		check({rd[29:0], resp}, 32'h0000_0003);
		acc(1'b1, aps_pkg::IDX_ARM, 16'h3af0);
		acc(1'b1, aps_pkg::IDX_A_PIN_HI, 16'h2000);
		acc(1'b1, aps_pkg::IDX_B_DAC_LO, 16'h0100);
		acc(1'b1, aps_pkg::IDX_B_PIN_LO, 16'h0002);
		ev(12'h800, 19'h4_0f00);
		ev(12'h100, 19'h2_f000);
		ev(12'h020, 19'h1_0011);
		ev(12'h010, 19'h0_0000);
		ev(12'h400, 19'h0_0000);
		ev(12'h920, 19'h7_ff11);
		acc(1'b1, aps_pkg::IDX_ARM, 16'h0000);
		ev(12'h100, 19'h2_0000);
		acc(1'b1, aps_pkg::IDX_ARM, 16'h2000);
		ev(12'h020, 19'h1_0014);
		ev(12'h000, 19'h0_0000);
		give_verdict();
	end
endmodule // aps_bank_tb
